// file: design/irq_enable_params.svh
// Register offsets, field masks, reset values and bus codes of the interrupt enable block.
`ifndef IRQ_ENABLE_PARAMS_SVH
`define IRQ_ENABLE_PARAMS_SVH

`define IEM_ADDR_W        8
`define IEM_ENABLE_OFFS   8'h90
`define IEM_STATUS_OFFS   8'h94
`define IEM_PENDING_OFFS  8'h98
`define IEM_ENABLE_RESET  16'h0000
`define IEM_STATUS_RESET  16'h0300
`define IEM_ENABLE_WMASK  16'hfffd
`define IEM_SOURCE_MASK   16'heb7d
`define IEM_DELAYED_BIT   0
`define IEM_RESP_OKAY     2'h0
`define IEM_RESP_SLVERR   2'h2

`endif

// file: design/irq_enable_pkg.sv
// Types shared by the interrupt enable block, its assertions and its bench.
package irq_enable_pkg;

  // One bit per interrupt source, in register bit order from 15 down to 0.
  typedef struct packed {
    logic link_change_irq_en;
    logic tx_done_irq_en;
    logic rx_frame_irq_en;
    logic rsvd12;
    logic rx_overrun_irq_en;
    logic rsvd10;
    logic tx_proc_stopped_irq_en;
    logic rx_proc_stopped_irq_en;
    logic rsvd7;
    logic tx_space_avail_irq_en;
    logic wake_frame_irq_en;
    logic wake_packet_irq_en;
    logic linkup_wake_irq_en;
    logic energy_wake_irq_en;
    logic rsvd1;
    logic delayed_energy_irq_en;
  } irq_bits_type;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_type;

endpackage

// file: design/irq_flag_bank.sv
// Sticky interrupt status flags, set by source events and cleared by writing one.
`timescale 1ns/1ps
`include "irq_enable_params.svh"

module irq_flag_bank #(
  parameter int                WIDTH     = 16,
  parameter logic [WIDTH-1:0]  RESET_VAL = `IEM_STATUS_RESET,
  parameter logic [WIDTH-1:0]  LIVE_MASK = `IEM_SOURCE_MASK
) (
  // Clock and reset.
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // Set and clear requests.
  input  wire logic [WIDTH-1:0]  setVec,
  input  wire logic [WIDTH-1:0]  clrVec,
  // Flag state.
  output logic      [WIDTH-1:0]  flagVec
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } bank_state_type;

  bank_state_type    state_r;
  bank_state_type    state_nxt;
  logic [WIDTH-1:0]  flagNxt;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_flag
      // A set in the same cycle as a clear wins, so no event is lost.
      assign flagNxt[i] = LIVE_MASK[i] & (setVec[i] | (state_r.flags[i] & ~clrVec[i]));
    end
  endgenerate

  always_comb
  begin
    state_nxt       = state_r;
    state_nxt.flags = flagNxt;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r.flags <= RESET_VAL;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign flagVec = state_r.flags;

endmodule // irq_flag_bank

// file: design/irq_enable_mask.sv
// Interrupt enable and status registers behind an AXI4-Lite slave, driving one interrupt line.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "irq_enable_params.svh"

module irq_enable_mask #(
  parameter int ADDR_W = `IEM_ADDR_W
) (
  // Clock and reset.
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  // AXI4-Lite write address channel.
  input  wire logic [ADDR_W-1:0]            awaddr,
  input  wire logic                         awvalid,
  output logic                              awready,
  // AXI4-Lite write data channel.
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  // AXI4-Lite write response channel.
  output logic [1:0]                        bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  // AXI4-Lite read address channel.
  input  wire logic [ADDR_W-1:0]            araddr,
  input  wire logic                         arvalid,
  output logic                              arready,
  // AXI4-Lite read data channel.
  output logic [31:0]                       rdata,
  output logic [1:0]                        rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  // Interrupt sources and device readiness.
  input  wire irq_enable_pkg::irq_bits_type sourceEvents,
  input  wire logic                         hostReady,
  // Interrupt line to the host.
  output logic                              irqOut
);

  import irq_enable_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0] awAddr;
    logic              awHave;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              wHave;
    wr_state_type      wrState;
    logic [1:0]        bResp;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
    irq_bits_type      enable;
  } slave_state_type;

  slave_state_type  state_r;
  slave_state_type  state_nxt;
  irq_bits_type     statusFlags;
  irq_bits_type     clearReq;
  irq_bits_type     pendingBits;
  logic [15:0]      laneMask;
  logic [15:0]      enableMerged;
  logic             awTake;
  logic             wTake;
  logic             haveAddr;
  logic             haveData;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0]      wrData;
  logic [3:0]       wrStrb;
  logic             doWrite;
  logic             wrHitEnable;
  logic             wrHitStatus;
  logic             wrHitPending;
  logic             rdHitEnable;
  logic             rdHitStatus;
  logic             rdHitPending;

  localparam logic [$bits(irq_bits_type)-1:0] SOURCE_MASK = `IEM_SOURCE_MASK;

  // Channel readiness follows the holding registers.
  assign awready = ~state_r.awHave & (state_r.wrState == WR_IDLE);
  assign wready  = ~state_r.wHave & (state_r.wrState == WR_IDLE);
  assign arready = ~state_r.rValid;
  assign bvalid  = (state_r.wrState == WR_RESP);
  assign bresp   = state_r.bResp;
  assign rvalid  = state_r.rValid;
  assign rdata   = state_r.rData;
  assign rresp   = state_r.rResp;

  assign awTake   = awvalid & awready;
  assign wTake    = wvalid & wready;
  assign haveAddr = state_r.awHave | awTake;
  assign haveData = state_r.wHave | wTake;
  assign wrAddr   = state_r.awHave ? state_r.awAddr : awaddr;
  assign wrData   = state_r.wHave ? state_r.wData : wdata;
  assign wrStrb   = state_r.wHave ? state_r.wStrb : wstrb;
  assign doWrite  = haveAddr & haveData & (state_r.wrState == WR_IDLE);

  // Write address decode; an address that hits nothing gets an error response.
  always_comb
  begin
    wrHitEnable  = 1'b0;
    wrHitStatus  = 1'b0;
    wrHitPending = 1'b0;
    if (wrAddr == `IEM_ENABLE_OFFS)
    begin
      wrHitEnable = 1'b1;
    end
    else if (wrAddr == `IEM_STATUS_OFFS)
    begin
      wrHitStatus = 1'b1;
    end
    else if (wrAddr == `IEM_PENDING_OFFS)
    begin
      wrHitPending = 1'b1;
    end
  end

  // Read address decode, independent of any write in flight.
  always_comb
  begin
    rdHitEnable  = 1'b0;
    rdHitStatus  = 1'b0;
    rdHitPending = 1'b0;
    if (araddr == `IEM_ENABLE_OFFS)
    begin
      rdHitEnable = 1'b1;
    end
    else if (araddr == `IEM_STATUS_OFFS)
    begin
      rdHitStatus = 1'b1;
    end
    else if (araddr == `IEM_PENDING_OFFS)
    begin
      rdHitPending = 1'b1;
    end
  end

  // Byte strobes select which halves of the 16-bit registers a write touches.
  assign laneMask = {{8{wrStrb[1]}}, {8{wrStrb[0]}}};

  assign enableMerged = (state_r.enable & ~(laneMask & `IEM_ENABLE_WMASK))
                      | (wrData[15:0] & laneMask & `IEM_ENABLE_WMASK);

  always_comb
  begin
    clearReq = '0;
    if (doWrite && wrHitStatus)
    begin
      clearReq = wrData[15:0] & laneMask;
    end
  end

  irq_flag_bank #(
    .WIDTH     (16),
    .RESET_VAL (`IEM_STATUS_RESET),
    .LIVE_MASK (`IEM_SOURCE_MASK)
  ) u_flags (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .setVec   (sourceEvents),
    .clrVec   (clearReq),
    .flagVec  (statusFlags)
  );

  genvar b;
  generate
    for (b = 0; b < $bits(irq_bits_type); b++)
    begin : g_gate
      if (b == `IEM_DELAYED_BIT)
      begin : g_delayed
        assign pendingBits[b] = statusFlags[b] & state_r.enable[b] & SOURCE_MASK[b] & hostReady;
      end
      else
      begin : g_direct
        assign pendingBits[b] = statusFlags[b] & state_r.enable[b] & SOURCE_MASK[b];
      end
    end
  endgenerate

  assign irqOut = |pendingBits;

  always_comb
  begin
    state_nxt = state_r;

    if (awTake)
    begin
      state_nxt.awAddr = awaddr;
      state_nxt.awHave = 1'b1;
    end
    if (wTake)
    begin
      state_nxt.wData = wdata;
      state_nxt.wStrb = wstrb;
      state_nxt.wHave = 1'b1;
    end

    case (state_r.wrState)
      WR_IDLE:
      begin
        if (doWrite)
        begin
          state_nxt.awHave  = 1'b0;
          state_nxt.wHave   = 1'b0;
          state_nxt.wrState = WR_RESP;
          state_nxt.bResp   = `IEM_RESP_OKAY;
          if (wrHitEnable)
          begin
            state_nxt.enable = enableMerged;
          end
          else if (wrHitStatus)
          begin
            state_nxt.bResp = `IEM_RESP_OKAY;
          end
          else if (wrHitPending)
          begin
            state_nxt.bResp = `IEM_RESP_OKAY;
          end
          else
          begin
            state_nxt.bResp = `IEM_RESP_SLVERR;
          end
        end
      end
      WR_RESP:
      begin
        if (bready)
        begin
          state_nxt.wrState = WR_IDLE;
        end
      end
      default:
      begin
        state_nxt.wrState = WR_IDLE;
      end
    endcase

    if (state_r.rValid && rready)
    begin
      state_nxt.rValid = 1'b0;
    end
    if (arvalid && arready)
    begin
      state_nxt.rValid = 1'b1;
      state_nxt.rResp  = `IEM_RESP_OKAY;
      state_nxt.rData  = '0;
      if (rdHitEnable)
      begin
        state_nxt.rData[15:0] = state_r.enable;
      end
      else if (rdHitStatus)
      begin
        state_nxt.rData[15:0] = statusFlags;
      end
      else if (rdHitPending)
      begin
        state_nxt.rData[15:0] = pendingBits;
      end
      else
      begin
        state_nxt.rResp = `IEM_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r.awAddr  <= '0;
      state_r.awHave  <= 1'b0;
      state_r.wData   <= '0;
      state_r.wStrb   <= '0;
      state_r.wHave   <= 1'b0;
      state_r.wrState <= WR_IDLE;
      state_r.bResp   <= `IEM_RESP_OKAY;
      state_r.rValid  <= 1'b0;
      state_r.rData   <= '0;
      state_r.rResp   <= `IEM_RESP_OKAY;
      state_r.enable  <= `IEM_ENABLE_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

endmodule // irq_enable_mask

// file: test/irq_enable_mask_sva.sv
// Bus handshake and interrupt line checks for the interrupt enable block.
`timescale 1ns/1ps

module irq_enable_mask_sva (
  // Clock and reset.
  input wire logic                         core_clk,
  input wire logic                         sys_rst,
  // Bus handshakes.
  input wire logic                         awvalid,
  input wire logic                         awready,
  input wire logic                         wvalid,
  input wire logic                         wready,
  input wire logic                         bvalid,
  input wire logic                         bready,
  input wire logic                         arvalid,
  input wire logic                         arready,
  input wire logic                         rvalid,
  input wire logic                         rready,
  // Interrupt side.
  input wire irq_enable_pkg::irq_bits_type sourceEvents,
  input wire logic                         hostReady,
  input wire logic                         irqOut
);
  import irq_enable_pkg::*;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  chk_wr_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write response missing");
  chk_b_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  chk_b_once: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  chk_aw_block: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted during response");
  chk_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read response missing");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid)
    else $error("read response dropped early");
  chk_ar_block: assert property (rvalid |-> !arready)
    else $error("read accepted during response");
  chk_irq_cause: assert property ($rose(irqOut) |-> $past(sourceEvents) != 16'h0 || $rose(bvalid) || $rose(hostReady))
    else $error("interrupt rose without cause");
  chk_irq_drop: assert property ($fell(irqOut) |-> $rose(bvalid) || $fell(hostReady))
    else $error("interrupt fell without cause");
endmodule // irq_enable_mask_sva

bind irq_enable_mask irq_enable_mask_sva chk (.core_clk, .sys_rst, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .sourceEvents, .hostReady, .irqOut);

// file: test/irq_enable_mask_tb_top.sv
// Self-checking bench for the interrupt enable block.
`timescale 1ns/1ps
`include "irq_enable_params.svh"

module irq_enable_mask_tb_top;
  import irq_enable_pkg::*;

  localparam logic [7:0]  EN = `IEM_ENABLE_OFFS;
  localparam logic [7:0]  ST = `IEM_STATUS_OFFS;
  localparam logic [7:0]  PD = `IEM_PENDING_OFFS;
  localparam logic [1:0]  OK = `IEM_RESP_OKAY;
  localparam logic [1:0]  ER = `IEM_RESP_SLVERR;
  localparam logic [15:0] LIVE = 16'heb7d;

  logic         core_clk = 0;
  logic         sys_rst = 1;
  logic [7:0]   awaddr = 0;
  logic [7:0]   araddr = 0;
  logic [31:0]  wdata = 0;
  logic [3:0]   wstrb = 0;
  logic         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, hostReady = 0;
  logic         awready, wready, bvalid, arready, rvalid, irqOut;
  logic [31:0]  rdata;
  logic [1:0]   bresp, rresp;
  irq_bits_type sourceEvents = '0;
  int           n_fail = 0;
  int           compares = 0;

  always #10 core_clk = ~core_clk;

  irq_enable_mask dut (.core_clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .sourceEvents, .hostReady, .irqOut);

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er, input logic [3:0] s = 4'hf);
    logic ad, dd;
    ad = 0;
    dd = 0;
    awaddr <= a;
    wdata <= {16'h0, d};
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && dd))
    begin
      @(posedge core_clk);
      ad = ad | awready;
      dd = dd | wready;
      awvalid <= !ad;
      wvalid <= !dd;
    end
    do @(posedge core_clk); while (!bvalid);
    bready <= 0;
    chk(32'(bresp), 32'(er));
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 0;
    do @(posedge core_clk); while (!rvalid);
    rready <= 0;
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
    @(posedge core_clk);
  endtask

  task automatic ev(input int i);
    sourceEvents <= irq_bits_type'(16'h1 << i);
    @(posedge core_clk);
    sourceEvents <= '0;
    @(posedge core_clk);
  endtask

  task automatic conclude();
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 0;
    @(posedge core_clk);
    rd(EN, 32'h0, OK); // enable bits reset clear
    rd(ST, 32'h0300, OK); // status reset value
    chk(32'(irqOut), 32'h0); // no interrupt after reset
    wr(EN, 16'hffff, OK); // set every writable bit
    rd(EN, 32'h0000fffd, OK); // bit 1 reads zero
    wr(EN, 16'h0, OK); // clear all enables
    wr(ST, 16'hffff, OK); // clear reset status
    hostReady <= 1;
    // Each source: masked, enabled, disabled, re-enabled, read, cleared.
    for (int i = 0; i < 16; i++)
    begin
      ev(i); // raise one source
      chk(32'(irqOut), 32'h0); // masked event stays quiet
      wr(EN, 16'h1 << i, OK); // enable that source
      chk(32'(irqOut), 32'(LIVE[i])); // per-bit gating, reserved bits inert
      wr(EN, 16'h0, OK); // disable it again
      chk(32'(irqOut), 32'h0); // disabling drops the line
      wr(EN, 16'h1 << i, OK); // re-enable it
      rd(ST, 32'(LIVE & (16'h1 << i)), OK); // status survives a read
      chk(32'(irqOut), 32'(LIVE[i])); // line still high
      wr(ST, 16'h1 << i, OK); // clear by writing one
      chk(32'(irqOut), 32'h0); // write one clears
    end
    wr(EN, 16'h0001, OK); // delayed energy enable only
    hostReady <= 0;
    ev(0); // event while not ready
    chk(32'(irqOut), 32'h0); // held back until ready
    rd(PD, 32'h0, OK); // pending view held back too
    hostReady <= 1;
    @(posedge core_clk);
    chk(32'(irqOut), 32'h1); // presented once ready
    rd(PD, 32'h1, OK); // pending view shows it
    wr(PD, 16'hffff, OK); // pending view ignores writes
    wr(8'h9c, 16'h1234, ER); // unmapped write refused
    rd(8'h9c, 32'h0, ER); // unmapped read refused
    rd(EN, 32'h1, OK); // unmapped write had no effect
    wr(EN, 16'hffff, OK, 4'h1); // low byte lane only
    rd(EN, 32'h00fd, OK); // high byte kept, bit 1 zero
    wr(EN, 16'h2000, OK, 4'h2); // high byte lane only
    rd(EN, 32'h20fd, OK); // low byte kept
    chk(32'(irqOut), 32'h1); // line still high
    conclude();
  end

  initial
  begin
    repeat (8000) @(posedge core_clk);
    n_fail++;
    conclude();
  end
endmodule // irq_enable_mask_tb_top
